// ===== ufcp_regs.vh
// command codes, field positions, reset values and limits of the command port
`ifndef UFCP_REGS_VH
`define UFCP_REGS_VH
// upper nibble of a command code selects its class
`define UFCP_NIB_WRBUF 4'h0
`define UFCP_NIB_RDBUF 4'h1
`define UFCP_NIB_WRSETUP 4'h2
`define UFCP_NIB_RDSETUP 4'h3
`define UFCP_NIB_STALL 4'h4
`define UFCP_NIB_RDSTATE 4'h5
`define UFCP_NIB_VALIDATE 4'h6
`define UFCP_NIB_CLEAR 4'h7
`define UFCP_NIB_UNSTALL 4'h8
`define UFCP_NIB_RDFAULT 4'hA
`define UFCP_NIB_CHECK 4'hD
// endpoint numbers of the control pair
`define UFCP_EP_CTRL_OUT 4'h0
`define UFCP_EP_CTRL_IN 4'h1
// single codes
`define UFCP_CMD_ACK_SETUP 8'hF4
`define UFCP_CMD_RESET 8'hF6
`define UFCP_CMD_ADDR_WR 8'hB6
`define UFCP_CMD_ADDR_RD 8'hB7
`define UFCP_CMD_MODE_WR 8'hB8
`define UFCP_CMD_MODE_RD 8'hB9
`define UFCP_CMD_HW_WR 8'hBA
`define UFCP_CMD_HW_RD 8'hBB
`define UFCP_CMD_IMASK_WR 8'hC2
`define UFCP_CMD_IMASK_RD 8'hC3
`define UFCP_CMD_DMACFG_WR 8'hF0
`define UFCP_CMD_DMACFG_RD 8'hF1
`define UFCP_CMD_DMACNT_WR 8'hF2
`define UFCP_CMD_DMACNT_RD 8'hF3
// endpoint setup field: isochronous type
`define UFCP_ISO_BIT 4
// payload limits in bytes
`define UFCP_MAX_ISO 11'h3FF
`define UFCP_MAX_BULK 11'h040
// reset values
`define UFCP_RST_BYTE 8'h00
`define UFCP_RST_WORD 16'h0000
`define UFCP_RST_DWORD 32'h00000000
`endif

// ===== ufcp_len_track.v
// length prefix capture and payload word counter for one buffer transfer
`timescale 1ns/10ps
module ufcp_len_track
(
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire start,
    input wire step,
    input wire [15:0] word,
    input wire [10:0] max_len,
    output wire captured,
    output wire last,
    output wire odd,
    output wire done
);
    reg have_len;
    reg len_odd;
    reg [9:0] words_left;
    wire [10:0] len_cut;
    wire [10:0] len_sum;

    // longer prefixes are clipped to the endpoint payload limit
    assign len_cut = (word > {5'h00, max_len}) ? max_len : word[10:0];
    assign len_sum = len_cut + 11'h001;

    // prefix first, then (N+1) div 2 payload words
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            have_len <= 1'b0;
            len_odd <= 1'b0;
            words_left <= 10'h000;
        end
        else if (ce)
        begin
            if (start)
            begin
                have_len <= 1'b0;
                words_left <= 10'h000;
            end
            else if (step && !have_len)
            begin
                have_len <= 1'b1;
                len_odd <= len_cut[0];
                words_left <= len_sum[10:1];
            end
            else if (step && words_left != 10'h000)
            begin
                words_left <= words_left - 10'h001;
            end
        end
    end

    assign captured = have_len;
    assign last = have_len && (words_left == 10'h001);
    assign odd = len_odd;
    assign done = have_len && (words_left == 10'h000);
endmodule // ufcp_len_track

// ===== ufcp_command_port.v
// command interpreter between the microprocessor bus and the usb function controller
// Function
// - select bit high on write takes command byte
// - commands without data act at once
// - select bit low moves data word
// - wide registers go low word first
// - upper byte ignored in command phase
// - odd length: last upper byte not sent
// - buffers start with two-byte length prefix
// - codes 20h-2Fh write endpoint setup word
// - codes 30h-3Fh read endpoint setup word
// - validate only control in and endpoints 2-15
// - code F4h acknowledges setup, no data
// - write buffers 01h-0Fh, payload limits 1023/64
// - check commands leave status flags unchanged
// - N bytes take (N+1) div 2 words
`timescale 1ns/10ps
`include "ufcp_regs.vh"
module ufcp_command_port
(
    input wire CORE_CLK,
    input wire RESETN,
    input wire CE,
    input wire CMD_SEL,
    input wire WR_STB,
    input wire RD_STB,
    input wire [15:0] DATA_IN,
    output reg [15:0] DATA_OUT,
    output wire DATA_OE_N,
    output reg RD_VALID,
    output wire [127:0] EP_SETUP,
    input wire [127:0] EP_STATE,
    input wire [127:0] EP_FAULT,
    output reg [3:0] EP_INDEX,
    output reg STALL_SET,
    output reg STALL_CLR,
    output reg BUF_VALIDATE,
    output reg BUF_CLEAR,
    output reg SETUP_ACK,
    output reg DEV_RESET,
    output reg STATE_CLR,
    output reg [15:0] TX_LEN,
    output reg [15:0] TX_DATA,
    output reg TX_VALID,
    output reg TX_HIGH_EN,
    output reg TX_LAST,
    output wire RX_REQ,
    input wire [15:0] RX_DATA,
    output reg [7:0] FUNC_ADDR,
    output reg [7:0] OP_MODE,
    output reg [15:0] HW_SETUP,
    output reg [31:0] INT_MASK,
    output reg [15:0] DMA_SETUP,
    output reg [15:0] DMA_COUNT
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DATA = 2'b10;

    reg [1:0] state;
    reg [7:0] cur_cmd;
    reg [1:0] word_idx;
    reg [7:0] ep_setup [0:15];
    reg [15:0] rd_word;
    integer i;

    wire [3:0] nib;
    wire [3:0] ep;
    wire cmd_wr;
    wire data_wr;
    wire data_rd;
    wire wr_buf;
    wire rd_buf;
    wire trk_cap;
    wire trk_last;
    wire trk_odd;
    wire trk_done;
    wire [10:0] max_len;
    wire trk_step;

    // legal codes; the illegal buffer, validate and clear codes fall out
    function legal;
        input [7:0] c;
        begin
            case (c[7:4])
                `UFCP_NIB_WRBUF: legal = (c[3:0] != `UFCP_EP_CTRL_OUT);
                `UFCP_NIB_RDBUF: legal = (c[3:0] != `UFCP_EP_CTRL_IN);
                `UFCP_NIB_VALIDATE: legal = (c[3:0] != `UFCP_EP_CTRL_OUT);
                `UFCP_NIB_CLEAR: legal = (c[3:0] != `UFCP_EP_CTRL_IN);
                `UFCP_NIB_WRSETUP, `UFCP_NIB_RDSETUP, `UFCP_NIB_STALL,
                `UFCP_NIB_RDSTATE, `UFCP_NIB_UNSTALL, `UFCP_NIB_RDFAULT,
                `UFCP_NIB_CHECK: legal = 1'b1;
                default: legal = (c == `UFCP_CMD_ACK_SETUP) || (c == `UFCP_CMD_RESET)
                    || needs_reg(c);
            endcase
        end
    endfunction

    // codes that address a plain control register
    function needs_reg;
        input [7:0] c;
        begin
            case (c)
                `UFCP_CMD_ADDR_WR, `UFCP_CMD_ADDR_RD, `UFCP_CMD_MODE_WR,
                `UFCP_CMD_MODE_RD, `UFCP_CMD_HW_WR, `UFCP_CMD_HW_RD,
                `UFCP_CMD_IMASK_WR, `UFCP_CMD_IMASK_RD, `UFCP_CMD_DMACFG_WR,
                `UFCP_CMD_DMACFG_RD, `UFCP_CMD_DMACNT_WR,
                `UFCP_CMD_DMACNT_RD: needs_reg = 1'b1;
                default: needs_reg = 1'b0;
            endcase
        end
    endfunction

    // legal codes that have a data phase
    function has_data;
        input [7:0] c;
        begin
            case (c[7:4])
                `UFCP_NIB_WRBUF, `UFCP_NIB_RDBUF, `UFCP_NIB_WRSETUP,
                `UFCP_NIB_RDSETUP, `UFCP_NIB_RDSTATE, `UFCP_NIB_RDFAULT,
                `UFCP_NIB_CHECK: has_data = 1'b1;
                default: has_data = needs_reg(c);
            endcase
        end
    endfunction

    // command byte from low lane only, upper lane ignored
    assign cmd_wr = WR_STB && CMD_SEL;
    assign data_wr = WR_STB && !CMD_SEL && (state == ST_DATA);
    assign data_rd = RD_STB && !CMD_SEL && (state == ST_DATA);
    assign nib = cur_cmd[7:4];
    assign ep = cur_cmd[3:0];
    assign wr_buf = (nib == `UFCP_NIB_WRBUF);
    assign rd_buf = (nib == `UFCP_NIB_RDBUF);

    // payload limit by endpoint type
    assign max_len = ep_setup[ep][`UFCP_ISO_BIT] ? `UFCP_MAX_ISO : `UFCP_MAX_BULK;

    // receive words are fetched only while payload remains
    assign RX_REQ = CE && data_rd && rd_buf && !trk_done;
    assign trk_step = (data_wr && wr_buf && !trk_done) || RX_REQ;
    assign DATA_OE_N = !RD_VALID;

    ufcp_len_track u_track
    (
        .clk(CORE_CLK),
        .resetn(RESETN),
        .ce(CE),
        .start(cmd_wr),
        .step(trk_step),
        .word(rd_buf ? RX_DATA : DATA_IN),
        .max_len(max_len),
        .captured(trk_cap),
        .last(trk_last),
        .odd(trk_odd),
        .done(trk_done)
    );

    // endpoint setup registers exposed as one flat vector
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_setup
            assign EP_SETUP[g*8 +: 8] = ep_setup[g];
        end
    endgenerate

    // read word selected by the last command and the word index
    always @*
    begin
        rd_word = `UFCP_RST_WORD;
        if (word_idx == 2'b00)
        begin
            case (nib)
                `UFCP_NIB_RDSETUP: rd_word = {8'h00, ep_setup[ep]};
                `UFCP_NIB_RDSTATE, `UFCP_NIB_CHECK: rd_word = {8'h00, EP_STATE[ep*8 +: 8]};
                `UFCP_NIB_RDFAULT: rd_word = {8'h00, EP_FAULT[ep*8 +: 8]};
                default:
                begin
                    case (cur_cmd)
                        `UFCP_CMD_ADDR_RD: rd_word = {8'h00, FUNC_ADDR};
                        `UFCP_CMD_MODE_RD: rd_word = {8'h00, OP_MODE};
                        `UFCP_CMD_HW_RD: rd_word = HW_SETUP;
                        `UFCP_CMD_IMASK_RD: rd_word = INT_MASK[15:0];
                        `UFCP_CMD_DMACFG_RD: rd_word = DMA_SETUP;
                        `UFCP_CMD_DMACNT_RD: rd_word = DMA_COUNT;
                        default: rd_word = `UFCP_RST_WORD;
                    endcase
                end
            endcase
        end
        else if (word_idx == 2'b01 && cur_cmd == `UFCP_CMD_IMASK_RD)
        begin
            rd_word = INT_MASK[31:16];
        end
    end

    // command phase, data phase sequencing and pulses
    always @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            state <= ST_IDLE;
            cur_cmd <= `UFCP_RST_BYTE;
            word_idx <= 2'b00;
            EP_INDEX <= 4'h0;
            {STALL_SET, STALL_CLR, BUF_VALIDATE, BUF_CLEAR} <= 4'h0;
            {SETUP_ACK, DEV_RESET, STATE_CLR, TX_VALID} <= 4'h0;
            TX_HIGH_EN <= 1'b0;
            TX_LAST <= 1'b0;
            TX_LEN <= `UFCP_RST_WORD;
            TX_DATA <= `UFCP_RST_WORD;
            DATA_OUT <= `UFCP_RST_WORD;
            RD_VALID <= 1'b0;
        end
        else if (CE)
        begin
            {STALL_SET, STALL_CLR, BUF_VALIDATE, BUF_CLEAR} <= 4'h0;
            {SETUP_ACK, DEV_RESET, STATE_CLR, TX_VALID} <= 4'h0;
            RD_VALID <= 1'b0;
            if (cmd_wr)
            begin
                cur_cmd <= DATA_IN[7:0];
                EP_INDEX <= DATA_IN[3:0];
                word_idx <= 2'b00;
                case (state)
                    ST_IDLE, ST_DATA:
                        state <= (legal(DATA_IN[7:0]) && has_data(DATA_IN[7:0]))
                            ? ST_DATA : ST_IDLE;
                    default: state <= ST_IDLE;
                endcase
                // no-data commands act on the accepting edge
                if (legal(DATA_IN[7:0]) && !has_data(DATA_IN[7:0]))
                begin
                    case (DATA_IN[7:4])
                        `UFCP_NIB_STALL: STALL_SET <= 1'b1;
                        `UFCP_NIB_UNSTALL: STALL_CLR <= 1'b1;
                        `UFCP_NIB_VALIDATE: BUF_VALIDATE <= 1'b1;
                        `UFCP_NIB_CLEAR: BUF_CLEAR <= 1'b1;
                        default:
                        begin
                            SETUP_ACK <= (DATA_IN[7:0] == `UFCP_CMD_ACK_SETUP);
                            DEV_RESET <= (DATA_IN[7:0] == `UFCP_CMD_RESET);
                        end
                    endcase
                end
            end
            else if (data_wr || data_rd)
            begin
                if (word_idx != 2'b11)
                begin
                    word_idx <= word_idx + 2'b01;
                end
            end
            // transmit payload after the prefix, odd tail marked
            if (data_wr && wr_buf && !trk_done)
            begin
                if (!trk_cap)
                begin
                    TX_LEN <= DATA_IN;
                end
                else
                begin
                    TX_DATA <= DATA_IN;
                    TX_VALID <= 1'b1;
                    TX_LAST <= trk_last;
                    TX_HIGH_EN <= !(trk_last && trk_odd);
                end
            end
            // read data registered; status read clears, check does not
            if (data_rd)
            begin
                DATA_OUT <= rd_buf ? (trk_done ? `UFCP_RST_WORD : RX_DATA) : rd_word;
                RD_VALID <= 1'b1;
                STATE_CLR <= (nib == `UFCP_NIB_RDSTATE) && (word_idx == 2'b00);
            end
        end
    end

    // software-written registers; reset command restores defaults
    always @(posedge CORE_CLK)
    begin
        if (!RESETN || (CE && DEV_RESET))
        begin
            for (i = 0; i < 16; i = i + 1)
                ep_setup[i] <= `UFCP_RST_BYTE;
            FUNC_ADDR <= `UFCP_RST_BYTE;
            OP_MODE <= `UFCP_RST_BYTE;
            HW_SETUP <= `UFCP_RST_WORD;
            INT_MASK <= `UFCP_RST_DWORD;
            DMA_SETUP <= `UFCP_RST_WORD;
            DMA_COUNT <= `UFCP_RST_WORD;
        end
        else if (CE && data_wr && word_idx == 2'b00)
        begin
            if (nib == `UFCP_NIB_WRSETUP)
                ep_setup[ep] <= DATA_IN[7:0];
            case (cur_cmd)
                `UFCP_CMD_ADDR_WR: FUNC_ADDR <= DATA_IN[7:0];
                `UFCP_CMD_MODE_WR: OP_MODE <= DATA_IN[7:0];
                `UFCP_CMD_HW_WR: HW_SETUP <= DATA_IN;
                `UFCP_CMD_IMASK_WR: INT_MASK[15:0] <= DATA_IN;
                `UFCP_CMD_DMACFG_WR: DMA_SETUP <= DATA_IN;
                `UFCP_CMD_DMACNT_WR: DMA_COUNT <= DATA_IN;
                default: FUNC_ADDR <= FUNC_ADDR;
            endcase
        end
        else if (CE && data_wr && word_idx == 2'b01 && cur_cmd == `UFCP_CMD_IMASK_WR)
        begin
            INT_MASK[31:16] <= DATA_IN;
        end
    end
endmodule // ufcp_command_port

// ===== ufcp_properties.sv
// concurrent checks on the command port pins
`timescale 1ns/10ps
module ufcp_props
(
    input wire CORE_CLK,
    input wire RESETN,
    input wire CE,
    input wire CMD_SEL,
    input wire WR_STB,
    input wire RD_STB,
    input wire [15:0] DATA_IN,
    input wire DATA_OE_N,
    input wire RD_VALID,
    input wire [3:0] EP_INDEX,
    input wire SETUP_ACK,
    input wire BUF_VALIDATE,
    input wire STATE_CLR,
    input wire TX_VALID,
    input wire TX_LAST,
    input wire TX_HIGH_EN,
    input wire RX_REQ
);
    wire cmd = CE && WR_STB && CMD_SEL;
    reg chk;
    // remembers whether the last command was a status check
    always @(posedge CORE_CLK)
    begin
        if (!RESETN)
            chk <= 1'b0;
        else if (cmd)
            chk <= (DATA_IN[7:4] == 4'hD);
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    AST_OE_FOLLOWS_READ: assert property (DATA_OE_N == !RD_VALID)
        else $error("output enable disagrees with read valid");
    AST_OE_IDLE: assert property (CE && !(RD_STB && !CMD_SEL) |=> DATA_OE_N)
        else $error("output enable low without data read");
    AST_CMD_INDEX: assert property (cmd |=> EP_INDEX == $past(DATA_IN[3:0]))
        else $error("endpoint index not taken from command byte");
    AST_ACK_SETUP: assert property (cmd && DATA_IN[7:0] == 8'hF4 |=> SETUP_ACK)
        else $error("setup acknowledge missing");
    AST_ACK_ONLY_CMD: assert property (CE && !cmd |=> !SETUP_ACK)
        else $error("setup acknowledge without command");
    AST_VALIDATE_BAD: assert property (cmd && DATA_IN[7:0] == 8'h60 |=> !BUF_VALIDATE)
        else $error("validate on control out");
    AST_VALIDATE_OK: assert property (cmd && DATA_IN[7:4] == 4'h6 && DATA_IN[3:0] != 4'h0
        |=> BUF_VALIDATE)
        else $error("validate pulse missing");
    AST_RD_CAUSE: assert property (RD_VALID && $past(CE) |-> $past(RD_STB && !CMD_SEL))
        else $error("read valid without data read");
    AST_CHECK_KEEPS: assert property (STATE_CLR |-> !chk)
        else $error("status check cleared state");
    AST_RX_REQ: assert property (RX_REQ |-> CE && RD_STB && !CMD_SEL)
        else $error("receive request outside data read");
    AST_TX_HIGH: assert property (TX_VALID && !TX_LAST |-> TX_HIGH_EN)
        else $error("upper byte dropped before last word");
endmodule // ufcp_props
bind ufcp_command_port ufcp_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CE(CE),
    .CMD_SEL(CMD_SEL), .WR_STB(WR_STB), .RD_STB(RD_STB), .DATA_IN(DATA_IN),
    .DATA_OE_N(DATA_OE_N), .RD_VALID(RD_VALID), .EP_INDEX(EP_INDEX), .SETUP_ACK(SETUP_ACK),
    .BUF_VALIDATE(BUF_VALIDATE), .STATE_CLR(STATE_CLR), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_HIGH_EN(TX_HIGH_EN), .RX_REQ(RX_REQ));

// ===== ufcp_cpu_model.sv
// microprocessor bus master model for the command port
`timescale 1ns/10ps
module ufcp_cpu_model
(
    input wire clk,
    input wire [15:0] rdata,
    input wire rvalid,
    output reg sel,
    output reg wr,
    output reg rd,
    output reg [15:0] wdata
);
    // idle bus
    initial
    begin
        sel = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
    end
    // one whole aligned word per access, strobe held over one rising edge
    task access(input s, input w, input [15:0] d, output [15:0] q, output v);
    begin
        @(negedge clk);
        sel = s;
        wr = w;
        rd = !w;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        q = rdata;
        v = rvalid;
        wdata = ~d; // released bus shows no stale value
    end
    endtask
endmodule // ufcp_cpu_model

// ===== ufcp_command_port_bench.sv
// self-checking bench for the command port
`timescale 1ns/10ps
`include "ufcp_regs.vh"
module ufcp_command_port_bench;
    reg CORE_CLK = 1'b0;
    reg RESETN = 1'b0;
    reg CE = 1'b1;
    reg [127:0] ep_state;
    reg [15:0] rx_mem [0:40];
    reg [5:0] rx_ptr = 6'h00;
    wire sel, wr_stb, rd_stb, rd_valid, oe_n, rx_req, tx_valid, tx_last, tx_hi, state_clr;
    wire [15:0] din, dout, tx_len, tx_data, hw_setup, dma_setup, dma_count;
    wire stall_set, stall_clr, buf_val, buf_clr, setup_ack, dev_reset;
    wire [5:0] pulses = {stall_set, stall_clr, buf_val, buf_clr, setup_ack, dev_reset};
    wire [3:0] ep_index;
    wire [7:0] func_addr, op_mode;
    wire [127:0] ep_setup;
    wire [31:0] int_mask;
    wire [15:0] rx_data = rx_mem[rx_ptr];
    wire [127:0] ep_fault = ~ep_state;
    integer seed = 14926;
    integer n_mismatch = 0, n_compared = 0, cyc = 0, tx_n = 0, sc_n = 0, i, k, n;
    reg [15:0] q, w, ra, rb, last_d;
    reg [15:0] rv [0:4];
    reg v, last_l, last_h;
    reg [7:0] setup [0:15];
    reg [63:0] lst = 64'h71706062F4408172;
    reg [39:0] rlst = 40'hF2F0BAB8B6;
    always #4 CORE_CLK = ~CORE_CLK;
    ufcp_cpu_model u_cpu (.clk(CORE_CLK), .rdata(dout), .rvalid(rd_valid), .sel(sel),
        .wr(wr_stb), .rd(rd_stb), .wdata(din));
    ufcp_command_port u_ufcp_command_port (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CE(CE),
        .CMD_SEL(sel), .WR_STB(wr_stb), .RD_STB(rd_stb), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE_N(oe_n), .RD_VALID(rd_valid), .EP_SETUP(ep_setup), .EP_STATE(ep_state),
        .EP_FAULT(ep_fault), .EP_INDEX(ep_index), .STALL_SET(stall_set),
        .STALL_CLR(stall_clr), .BUF_VALIDATE(buf_val), .BUF_CLEAR(buf_clr),
        .SETUP_ACK(setup_ack), .DEV_RESET(dev_reset), .STATE_CLR(state_clr),
        .TX_LEN(tx_len), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_HIGH_EN(tx_hi),
        .TX_LAST(tx_last), .RX_REQ(rx_req), .RX_DATA(rx_data), .FUNC_ADDR(func_addr),
        .OP_MODE(op_mode), .HW_SETUP(hw_setup), .INT_MASK(int_mask),
        .DMA_SETUP(dma_setup), .DMA_COUNT(dma_count));
    // receive buffer steps on each request; transmit and status monitor; timeout
    always @(posedge CORE_CLK)
    begin
        if (rx_req)
            rx_ptr <= rx_ptr + 6'h01;
        cyc = cyc + 1;
        if (tx_valid)
        begin
            tx_n = tx_n + 1;
            last_l = tx_last;
            last_h = tx_hi;
            last_d = tx_data;
        end
        if (state_clr)
            sc_n = sc_n + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // expected one-cycle pulses of a data-less command, illegal codes give none
    function [5:0] pulse_exp(input [7:0] c);
    begin
        case (c[7:4])
            4'h4: pulse_exp = 6'h20;
            4'h8: pulse_exp = 6'h10;
            4'h6: pulse_exp = (c[3:0] != 4'h0) ? 6'h08 : 6'h00;
            4'h7: pulse_exp = (c[3:0] != 4'h1) ? 6'h04 : 6'h00;
            default: pulse_exp = (c == 8'hF4) ? 6'h02 : ((c == 8'hF6) ? 6'h01 : 6'h00);
        endcase
    end
    endfunction
    // byte registers: only the low lane is meaningful on a read
    function [15:0] reg_mask(input [7:0] c);
    begin
        reg_mask = (c == `UFCP_CMD_ADDR_WR || c == `UFCP_CMD_MODE_WR) ? 16'h00FF : 16'hFFFF;
    end
    endfunction
    task cmd(input [7:0] c);
    begin
        w = $random(seed);
        u_cpu.access(1'b1, 1'b1, {w[7:0], c}, q, v);
    end
    endtask
    task wr(input [15:0] d);
        u_cpu.access(1'b0, 1'b1, d, q, v);
    endtask
    task rd;
        u_cpu.access(1'b0, 1'b0, w, q, v);
    endtask
    task settle;
        repeat (2) @(negedge CORE_CLK);
    endtask
    task end_sim;
    begin
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // main sequence
    initial
    begin
        ep_state = {$random(seed), $random(seed), $random(seed), $random(seed)};
        for (i = 0; i < 41; i = i + 1)
            rx_mem[i] = $random(seed);
        repeat (8) @(negedge CORE_CLK);
        RESETN = 1'b1;
        chk(oe_n, 1);
        chk(int_mask, 0);
        chk(tx_len, 0);
        for (i = 0; i < 16; i = i + 1)
        begin
            setup[i] = $random(seed);
            setup[2][4] = 1'b0;
            cmd(8'h20 + i[7:0]);
            wr({w[15:8], setup[i]});
            chk(ep_setup[8*i +: 8], setup[i]);
        end
        for (i = 0; i < 16; i = i + 1)
        begin
            cmd(8'h30 + i[7:0]);
            rd;
            chk(v, 1);
            chk(q[7:0], setup[i]);
        end
        for (k = 0; k < 3; k = k + 1)
        begin
            n = (k == 0) ? 64 : (($random(seed) & 31) * 2 + 1);
            tx_n = 0;
            cmd(8'h02);
            wr(n);
            chk(tx_len, n);
            for (i = 0; i <= (n + 1) / 2; i = i + 1)
            begin
                ra = $random(seed);
                if (i < (n + 1) / 2)
                    rb = ra;
                wr(ra);
            end
            chk(tx_n, (n + 1) / 2);
            chk(last_d, rb);
            chk(last_l, 1);
            chk(last_h, !n[0]);
        end
        tx_n = 0;
        cmd(8'h00);
        wr(16'h0004);
        wr(16'h1234);
        settle;
        chk(tx_n, 0);
        n = ($random(seed) & 63) + 1;
        rx_mem[0] = n;
        rx_ptr = 6'h00;
        cmd(8'h10);
        rd;
        chk(q, n);
        for (i = 1; i <= (n + 1) / 2; i = i + 1)
        begin
            rd;
            if (n[0] && i == (n + 1) / 2)
                chk(q[7:0], rx_mem[i][7:0]);
            else
                chk(q, rx_mem[i]);
        end
        rd;
        chk(q, 0);
        chk(rx_ptr, (n + 1) / 2 + 1);
        cmd(8'h11);
        rd;
        chk(v, 0);
        ra = $random(seed);
        rb = $random(seed);
        cmd(`UFCP_CMD_IMASK_WR);
        wr(ra);
        wr(rb);
        chk(int_mask, {rb, ra});
        for (k = 0; k < 2; k = k + 1)
        begin
            cmd(`UFCP_CMD_IMASK_RD);
            rd;
            chk(q, ra);
        end
        rd;
        chk(q, rb);
        sc_n = 0;
        cmd(8'h53);
        rd;
        chk(q[7:0], ep_state[31:24]);
        cmd(8'hD3);
        rd;
        chk(q[7:0], ep_state[31:24]);
        settle;
        chk(sc_n, 1);
        cmd(8'hA3);
        rd;
        chk(q[7:0], ep_fault[31:24]);
        for (k = 0; k < 5; k = k + 1)
        begin
            rv[k] = $random(seed);
            cmd(rlst[8*k +: 8]);
            wr(rv[k]);
            cmd(rlst[8*k +: 8] + 8'h01);
            rd;
            chk(q & reg_mask(rlst[8*k +: 8]), rv[k] & reg_mask(rlst[8*k +: 8]));
        end
        chk({func_addr, op_mode}, {rv[0][7:0], rv[1][7:0]});
        chk(hw_setup, rv[2]);
        chk({dma_setup, dma_count}, {rv[3], rv[4]});
        for (k = 0; k < 8; k = k + 1)
        begin
            cmd(lst[8*k +: 8]);
            chk(pulses, pulse_exp(lst[8*k +: 8]));
            chk(ep_index, lst[8*k +: 4]);
        end
        cmd(`UFCP_CMD_RESET);
        chk(pulses, 6'h01);
        settle;
        chk(int_mask, 0);
        chk({func_addr, op_mode, hw_setup}, 0);
        chk({dma_setup, dma_count}, 0);
        end_sim;
    end
endmodule // ufcp_command_port_bench
